// ==== rtl/dpr_pkg.sv ====
// shared constants and pin bundle for the dual-port synchronous ram core
package dpr_pkg;
  localparam int AW = 15;                 // 32k words
  localparam int DW = 18;                 // word width
  localparam int BW = 9;                  // byte lane width
  localparam int NB = 2;                  // byte lanes per word
  localparam int NP = 2;                  // ports
  localparam logic [AW-1:0] MASK_RST = 15'h7fff;
  localparam logic [AW-1:0] CNT_RST = 15'h0000;
  localparam logic [AW-1:0] MBOX_P0 = 15'h7fff;  // mailbox of port 0
  localparam logic [AW-1:0] MBOX_P1 = 15'h7ffe;  // mailbox of port 1
  localparam logic [DW-1:0] DQ_RST = 18'h00000;

  // everything a host presents on one port, sampled together
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
    logic [NB-1:0] byte_en;               // byte_lane1_enable, byte_lane0_enable
    logic chip_select_active_low;
    logic chip_select_active_high;
    logic address_strobe_n;
    logic counter_advance_n;
    logic counter_clear_n;
    logic mask_access_select_n;
    logic rw_n;                           // low writes
    logic out_enable_n;
  } dpr_pin_s;

  localparam dpr_pin_s PIN_IDLE = '{addr: 15'h0000, dq: 18'h00000, byte_en: 2'h0,
    chip_select_active_low: 1'b1, chip_select_active_high: 1'b0,
    address_strobe_n: 1'b1, counter_advance_n: 1'b1, counter_clear_n: 1'b1,
    mask_access_select_n: 1'b1, rw_n: 1'b1, out_enable_n: 1'b1};
endpackage

// ==== rtl/dpr_core.sv ====
// two-port synchronous pipelined ram with burst counters, masks and mailboxes
// Overview of operation
// - both ports access any location independently, including same-location reads
// - read data passes an output register stage before reaching the data pins
// - each port has a burst counter loaded externally then advanced internally
// - write strobe is one internal cycle, independent of how long rw is low
// - chip select deasserted for one cycle powers port down, outputs inactive
// - data outputs return only after one full cycle with both selects asserted
// - array holds 18-bit words on a 15-bit address
// - global master reset clears the device asynchronously
// - byte-lane enables update only the selected lanes of a word
// - mask limits counter wrap bits; flag asserted while the counter sits at its top, released when it wraps
// - counter or mask value can be driven back on the address lines
// - retransmit: with a contiguous low mask, after wrap the counter returns to the block start
// - address strobe low with advance high uses and loads the external address
// - counter advance low increments counter unless strobe or clear asserted
// - counter clear zeroes unmasked counter bits, overriding strobe and advance
// - top two words are mailboxes; other port's write flags, own read clears
`timescale 1ns/1ns
module dpr_core (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic global_async_clear_n,
  input wire dpr_pkg::dpr_pin_s pin_i [dpr_pkg::NP],
  output logic [dpr_pkg::NP-1:0][dpr_pkg::AW-1:0] addr_o,
  output logic [dpr_pkg::NP-1:0] addr_oe_o,
  output logic [dpr_pkg::NP-1:0][dpr_pkg::DW-1:0] dq_o,
  output logic [dpr_pkg::NP-1:0] dq_oe_o,
  output logic [dpr_pkg::NP-1:0] mailbox_flag_n_o,
  output logic [dpr_pkg::NP-1:0] counter_wrap_flag_n_o
);

  // ************************************************************
  // helpers
  // ************************************************************

  // increment only the bits the mask lets move; fixed bits hold the block base
  function automatic logic [dpr_pkg::AW-1:0] masked_inc(input logic [dpr_pkg::AW-1:0] c,
                                                       input logic [dpr_pkg::AW-1:0] m);
    logic [dpr_pkg::AW-1:0] s;
    s = c + 15'h0001;
    masked_inc = (c & ~m) | (s & m);
  endfunction

  // high when every unmasked counter bit is one
  function automatic logic at_top(input logic [dpr_pkg::AW-1:0] c,
                                  input logic [dpr_pkg::AW-1:0] m);
    at_top = &(c | ~m);
  endfunction

  // ************************************************************
  // storage and per-port signals
  // ************************************************************

  logic [dpr_pkg::DW-1:0] mem [2**dpr_pkg::AW];
  dpr_pkg::dpr_pin_s meta_r [dpr_pkg::NP];
  dpr_pkg::dpr_pin_s smp_r [dpr_pkg::NP];
  logic [dpr_pkg::NP-1:0][dpr_pkg::AW-1:0] cnt_r;
  logic [dpr_pkg::NP-1:0][dpr_pkg::AW-1:0] mask_r;
  logic [dpr_pkg::NP-1:0][dpr_pkg::AW-1:0] acc_addr;
  logic [dpr_pkg::NP-1:0][dpr_pkg::DW-1:0] rd_q_r;
  logic [dpr_pkg::NP-1:0] rd_v_r;
  logic [dpr_pkg::NP-1:0] up_r;
  logic [dpr_pkg::NP-1:0] sel;
  logic [dpr_pkg::NP-1:0] wr;
  logic [dpr_pkg::NP-1:0] rd;
  logic [dpr_pkg::NP-1:0] rb;
  logic [dpr_pkg::NP-1:0][dpr_pkg::AW-1:0] mbox_addr;

  assign mbox_addr[0] = dpr_pkg::MBOX_P0;
  assign mbox_addr[1] = dpr_pkg::MBOX_P1;

  // ************************************************************
  // array write
  // ************************************************************

  // one write per sampled cycle, so the strobe never stretches with rw; a
  // same-address collision lets port 1 land last, which hosts must avoid
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < dpr_pkg::NP; p++) begin
      if (wr[p]) begin
        for (int b = 0; b < dpr_pkg::NB; b++) begin
          if (smp_r[p].byte_en[b]) begin
            mem[acc_addr[p]][b*dpr_pkg::BW +: dpr_pkg::BW] <=
              smp_r[p].dq[b*dpr_pkg::BW +: dpr_pkg::BW];
          end
        end
      end
    end
  end

  // ************************************************************
  // port logic
  // ************************************************************

  for (genvar p = 0; p < dpr_pkg::NP; p++) begin : g_port
    localparam int OP = 1 - p;

    // two flops on every pin before any logic looks at it
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        meta_r[p] <= dpr_pkg::PIN_IDLE;
        smp_r[p] <= dpr_pkg::PIN_IDLE;
      end else begin
        meta_r[p] <= pin_i[p];
        smp_r[p] <= meta_r[p];
      end
    end

    // decode of the sampled controls
    assign sel[p] = !smp_r[p].chip_select_active_low && smp_r[p].chip_select_active_high;
    assign rb[p] = !smp_r[p].address_strobe_n && !smp_r[p].counter_advance_n;
    assign acc_addr[p] = smp_r[p].address_strobe_n ? cnt_r[p] : smp_r[p].addr;
    assign wr[p] = sel[p] && !smp_r[p].rw_n && smp_r[p].mask_access_select_n && !rb[p];
    assign rd[p] = sel[p] && smp_r[p].rw_n && smp_r[p].mask_access_select_n && !rb[p];

    // burst counter and mask; clear beats readback, strobe and advance
    always_ff @(posedge sys_clk_i or negedge global_async_clear_n) begin
      if (!global_async_clear_n) begin
        cnt_r[p] <= dpr_pkg::CNT_RST;
        mask_r[p] <= dpr_pkg::MASK_RST;
      end else if (rst_i) begin
        cnt_r[p] <= dpr_pkg::CNT_RST;
        mask_r[p] <= dpr_pkg::MASK_RST;
      end else if (!smp_r[p].counter_clear_n) begin
        cnt_r[p] <= cnt_r[p] & ~mask_r[p];
      end else if (rb[p]) begin
        cnt_r[p] <= cnt_r[p];
      end else if (!smp_r[p].address_strobe_n) begin
        if (smp_r[p].mask_access_select_n) begin
          cnt_r[p] <= smp_r[p].addr;
        end else begin
          mask_r[p] <= smp_r[p].addr;
        end
      end else if (!smp_r[p].counter_advance_n) begin
        cnt_r[p] <= masked_inc(cnt_r[p], mask_r[p]);
      end
    end

    // wrap flag follows the counter: low while unmasked bits are all ones
    always_ff @(posedge sys_clk_i or negedge global_async_clear_n) begin
      if (!global_async_clear_n) begin
        counter_wrap_flag_n_o[p] <= 1'b1;
      end else if (rst_i) begin
        counter_wrap_flag_n_o[p] <= 1'b1;
      end else begin
        counter_wrap_flag_n_o[p] <= !at_top(cnt_r[p], mask_r[p]);
      end
    end

    // readback drives counter, or mask when mask access is selected
    always_ff @(posedge sys_clk_i or negedge global_async_clear_n) begin
      if (!global_async_clear_n) begin
        addr_o[p] <= dpr_pkg::CNT_RST;
        addr_oe_o[p] <= 1'b0;
      end else if (rst_i) begin
        addr_o[p] <= dpr_pkg::CNT_RST;
        addr_oe_o[p] <= 1'b0;
      end else begin
        addr_o[p] <= smp_r[p].mask_access_select_n ? cnt_r[p] : mask_r[p];
        addr_oe_o[p] <= rb[p] && sel[p];
      end
    end

    // read pipeline: array read then output register; ports never block
    // each other, so both may read one word in the same cycle
    always_ff @(posedge sys_clk_i or negedge global_async_clear_n) begin
      if (!global_async_clear_n) begin
        rd_q_r[p] <= dpr_pkg::DQ_RST;
        rd_v_r[p] <= 1'b0;
        up_r[p] <= 1'b0;
        dq_o[p] <= dpr_pkg::DQ_RST;
        dq_oe_o[p] <= 1'b0;
      end else if (rst_i) begin
        rd_q_r[p] <= dpr_pkg::DQ_RST;
        rd_v_r[p] <= 1'b0;
        up_r[p] <= 1'b0;
        dq_o[p] <= dpr_pkg::DQ_RST;
        dq_oe_o[p] <= 1'b0;
      end else begin
        if (rd[p]) begin
          rd_q_r[p] <= mem[acc_addr[p]];
        end
        rd_v_r[p] <= rd[p];
        up_r[p] <= sel[p];
        dq_o[p] <= rd_q_r[p];
        dq_oe_o[p] <= rd_v_r[p] && up_r[p] && sel[p] && !smp_r[p].out_enable_n;
      end
    end

    // mailbox flag: set by the other port's write, cleared by own read; set wins
    always_ff @(posedge sys_clk_i or negedge global_async_clear_n) begin
      if (!global_async_clear_n) begin
        mailbox_flag_n_o[p] <= 1'b1;
      end else if (rst_i) begin
        mailbox_flag_n_o[p] <= 1'b1;
      end else if (wr[OP] && acc_addr[OP] == mbox_addr[p]) begin
        mailbox_flag_n_o[p] <= 1'b0;
      end else if (rd[p] && acc_addr[p] == mbox_addr[p]) begin
        mailbox_flag_n_o[p] <= 1'b1;
      end
    end

    // ************************************************************
    // checks
    // ************************************************************

    chk_read_pipe_data: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      rd[p] |=> ##1 dq_o[p] == $past(rd_q_r[p]))
      else $error("read data did not pass the output stage");

    chk_clear_priority: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      !smp_r[p].counter_clear_n |=> cnt_r[p] == ($past(cnt_r[p]) & ~$past(mask_r[p])))
      else $error("counter clear did not zero unmasked bits");

    chk_strobe_load: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (smp_r[p].counter_clear_n && !smp_r[p].address_strobe_n && smp_r[p].counter_advance_n
       && smp_r[p].mask_access_select_n) |=> cnt_r[p] == $past(smp_r[p].addr))
      else $error("address strobe did not load the counter");

    chk_count_step: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (smp_r[p].counter_clear_n && smp_r[p].address_strobe_n && !smp_r[p].counter_advance_n
       && mask_r[p] == dpr_pkg::MASK_RST) |=> cnt_r[p] == $past(cnt_r[p]) + 15'h0001)
      else $error("counter did not advance by one");

    chk_power_down: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      !sel[p] |=> !dq_oe_o[p] ##1 !dq_oe_o[p])
      else $error("data driven while port deselected");

    chk_wake_delay: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      $rose(dq_oe_o[p]) |-> $past(sel[p]) && $past(up_r[p]))
      else $error("outputs woke without a full selected cycle");

    chk_wrap_flag: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (cnt_r[p] == mask_r[p] && mask_r[p] == dpr_pkg::MASK_RST) |=> !counter_wrap_flag_n_o[p])
      else $error("wrap flag missing at counter top");

    chk_mailbox_set: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (wr[OP] && acc_addr[OP] == mbox_addr[p]) |=> !mailbox_flag_n_o[p])
      else $error("mailbox flag not raised by other port write");

    chk_readback_value: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (rb[p] && sel[p] && smp_r[p].mask_access_select_n) |=> addr_oe_o[p]
        && addr_o[p] == $past(cnt_r[p]))
      else $error("counter readback wrong");

    chk_mailbox_clear: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (rd[p] && acc_addr[p] == mbox_addr[p] && !(wr[OP] && acc_addr[OP] == mbox_addr[p]))
        |=> mailbox_flag_n_o[p])
      else $error("mailbox flag not cleared by own read");

    chk_readback_hold: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (smp_r[p].counter_clear_n && rb[p]) |=> cnt_r[p] == $past(cnt_r[p]))
      else $error("counter moved during readback");

    chk_mask_load: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (smp_r[p].counter_clear_n && !smp_r[p].address_strobe_n && smp_r[p].counter_advance_n
       && !smp_r[p].mask_access_select_n) |=> mask_r[p] == $past(smp_r[p].addr))
      else $error("mask did not load from the address pins");

    // only a contiguous low mask wraps cleanly to the block base
    chk_block_return: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      (smp_r[p].counter_clear_n && smp_r[p].address_strobe_n && !smp_r[p].counter_advance_n
       && at_top(cnt_r[p], mask_r[p]) && (mask_r[p] & (mask_r[p] + 15'h0001)) == 15'h0000)
        |=> cnt_r[p] == ($past(cnt_r[p]) & ~$past(mask_r[p])))
      else $error("counter did not return to block start");

    chk_wrap_release: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      !at_top(cnt_r[p], mask_r[p]) |=> counter_wrap_flag_n_o[p])
      else $error("wrap flag low away from counter top");

    chk_addr_release: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      !rb[p] |=> !addr_oe_o[p])
      else $error("address lines driven outside readback");

    chk_deselect_idle: assert property (@(posedge sys_clk_i)
      disable iff (rst_i || !global_async_clear_n)
      !sel[p] |=> !addr_oe_o[p])
      else $error("address lines driven while port deselected");
  end

endmodule

// ==== tb/dpr_host.sv ====
// host-side pin driver for one port of the dual-port ram
`timescale 1ns/1ns
module dpr_host (
  output dpr_pkg::dpr_pin_s pin_o
);
  // ************
  // pin driver
  // ************
  // start deselected so nothing reaches the array before reset ends
  initial begin
    pin_o = dpr_pkg::PIN_IDLE;
  end
  // one host cycle; c = cs_low, cs_high, strobe, advance, clear, mask, rw
  // a strobe low with clear and advance high makes the port take addr and load it into its counter, or into its mask when mask access is selected
  task put(input logic [14:0] a, input logic [17:0] d, input logic [1:0] b,
    input logic [6:0] c);
    pin_o = '{addr: a, dq: d, byte_en: b, chip_select_active_low: c[6],
      chip_select_active_high: c[5], address_strobe_n: c[4], counter_advance_n: c[3],
      counter_clear_n: c[2], mask_access_select_n: c[1], rw_n: c[0], out_enable_n: 1'b0};
  endtask
endmodule

// ==== tb/test_dpr_core.sv ====
// self-checking bench for the dual-port synchronous ram core
`timescale 1ns/1ns
module test_dpr_core;
  // ************
  // harness
  // ************
  localparam logic [6:0] IDL = 7'h3f;  // selected, counter held, reading
  localparam logic [6:0] WR = 7'h2e;
  localparam logic [6:0] RD = 7'h2f;
  localparam logic [6:0] ADV = 7'h37;
  localparam logic [6:0] RB = 7'h27;
  localparam logic [6:0] MLD = 7'h2d;
  localparam logic [6:0] MRB = 7'h25;
  localparam logic [6:0] CLR = 7'h2b;  // clear together with a strobe
  localparam logic [6:0] DSL = 7'h7f;
  logic sys_clk_i;
  logic rst_i;
  logic global_async_clear_n;
  dpr_pkg::dpr_pin_s pin [dpr_pkg::NP];
  logic [1:0][14:0] addr_o;
  logic [1:0][17:0] dq_o;
  logic [1:0] addr_oe_o, dq_oe_o, mbox_flag_n, wrap_flag_n;
  int failures, check_count, cycles;
  dpr_host h0 (.pin_o(pin[0]));
  dpr_host h1 (.pin_o(pin[1]));
  dpr_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .global_async_clear_n(global_async_clear_n), .pin_i(pin), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .mailbox_flag_n_o(mbox_flag_n), .counter_wrap_flag_n_o(wrap_flag_n));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // a hang costs one mismatch and still ends in the closing report
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task check(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // both ports change pins just after an edge, then one cycle passes
  task cyc(input logic [6:0] c0, input logic [14:0] a0, input logic [17:0] d0,
    input logic [1:0] b0, input logic [6:0] c1 = IDL, input logic [14:0] a1 = 15'h0000,
    input logic [17:0] d1 = 18'h00000, input logic [1:0] b1 = 2'h0);
    h0.put(a0, d0, b0, c0);
    h1.put(a1, d1, b1, c1);
    @(posedge sys_clk_i);
    #1;
  endtask
  task idl(input int n);
    repeat (n) cyc(IDL, 15'h0000, 18'h00000, 2'h0);
  endtask
  // readback lands on the address lines three edges after the pins
  task rb(input logic [6:0] c, input logic [14:0] exp);
    cyc(c, 15'h0000, 18'h00000, 2'h0);
    idl(2);
    check(addr_o[0], exp);
    check(addr_oe_o[0], 1'b1);
  endtask
  // ************
  // tests
  // ************
  initial begin
    failures = 0;
    check_count = 0;
    cycles = 0;
    rst_i = 1'b1;
    global_async_clear_n = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    idl(3);
    check(mbox_flag_n, 2'h3);
    // the two ports write different words in one cycle
    cyc(WR, 15'h0010, 18'h2a5a5, 2'h3, WR, 15'h0020, 18'h1c3c3, 2'h3);
    cyc(RD, 15'h0010, 18'h00000, 2'h0, RD, 15'h0010, 18'h00000, 2'h0);
    idl(3);
    check(dq_o[0], 18'h2a5a5);
    check(dq_o[1], 18'h2a5a5);
    check(dq_oe_o, 2'h3);
    cyc(RD, 15'h0020, 18'h00000, 2'h0);
    idl(2);
    check(dq_o[0], 18'h2a5a5);
    idl(1);
    check(dq_o[0], 18'h1c3c3);
    $display("dual access test done");
    cyc(WR, 15'h0010, 18'h00000, 2'h1);
    cyc(RD, 15'h0010, 18'h00000, 2'h0);
    idl(3);
    check(dq_o[0], 18'h2a5a5 & 18'h3fe00);
    $display("byte lane test done");
    cyc(RD, 15'h0100, 18'h00000, 2'h0);
    repeat (2) cyc(ADV, 15'h0000, 18'h00000, 2'h0);
    rb(RB, 15'h0102);
    rb(RB, 15'h0102);
    cyc(MLD, 15'h0003, 18'h00000, 2'h0);
    rb(MRB, 15'h0003);
    cyc(RD, 15'h0041, 18'h00000, 2'h0);
    repeat (2) cyc(ADV, 15'h0000, 18'h00000, 2'h0);
    idl(3);
    check(wrap_flag_n[0], 1'b0);
    rb(RB, 15'h0043);
    cyc(ADV, 15'h0000, 18'h00000, 2'h0);
    idl(3);
    check(wrap_flag_n[0], 1'b1);
    rb(RB, 15'h0040);
    cyc(RD, 15'h0042, 18'h00000, 2'h0);
    cyc(CLR, 15'h0013, 18'h00000, 2'h0);
    rb(RB, 15'h0040);
    $display("counter and mask test done");
    cyc(DSL, 15'h0000, 18'h00000, 2'h0);
    idl(2);
    check(dq_oe_o[0], 1'b0);
    check(dq_oe_o[1], 1'b1);
    idl(1);
    check(dq_oe_o[0], 1'b0);
    idl(1);
    check(dq_oe_o[0], 1'b1);
    idl(1);
    check(dq_oe_o[0], 1'b1);
    $display("power down test done");
    cyc(IDL, 15'h0000, 18'h00000, 2'h0, WR, dpr_pkg::MBOX_P0, 18'h15555, 2'h3);
    idl(3);
    check(mbox_flag_n, 2'h2);
    cyc(RD, dpr_pkg::MBOX_P0, 18'h00000, 2'h0);
    idl(3);
    check(dq_o[0], 18'h15555);
    check(mbox_flag_n, 2'h3);
    // port 0 moves its counter off its mailbox so idle reads cannot clear the flag
    cyc(RD, 15'h0010, 18'h00000, 2'h0, WR, dpr_pkg::MBOX_P0, 18'h0aaaa, 2'h3);
    idl(3);
    check(mbox_flag_n, 2'h2);
    // the clear acts between edges, with no clock edge to help it
    global_async_clear_n = 1'b0;
    #2;
    check(mbox_flag_n, 2'h3);
    check(dq_oe_o, 2'h0);
    check(addr_oe_o, 2'h0);
    @(posedge sys_clk_i);
    #1;
    global_async_clear_n = 1'b1;
    idl(2);
    rb(RB, dpr_pkg::CNT_RST);
    rb(MRB, dpr_pkg::MASK_RST);
    $display("mailbox and clear test done");
    finish_test();
  end
endmodule
